// >>> common/bbw_pkg.sv
// Purpose: shared constants and types for the flash host controller
// Assumes: 200 MHz system clock, 24-bit word address, x16 data
// Notes:   reset pin timing figures are parameters with plain defaults
package bbw_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned ADDR_W        = 24;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned BLK_W         = 8;
  localparam int unsigned BANK_W        = 2;
  // block layout
  localparam logic [23:0] PARAM_BLK_WORDS  = 24'h008000;
  localparam logic [23:0] MAIN_BLK_WORDS   = 24'h020000;
  localparam logic [23:0] BANK_B_BASE      = 24'h200000;
  localparam logic [23:0] BANK_C_BASE      = 24'h800000;
  localparam logic [23:0] BANK_D_BASE      = 24'hE00000;
  localparam logic [23:0] TOP_PARAM_BASE   = 24'hFE0000;
  localparam logic [23:0] LOW_MAIN_BASE    = 24'h020000;
  localparam logic [7:0]  PARAM_BLKS_LOW   = 8'h04;
  localparam logic [7:0]  BLK_FIRST_BANK_B = 8'h13;
  localparam logic [7:0]  BLK_LAST         = 8'h85;
  localparam logic [7:0]  BLK_TOP_PARAM0   = 8'h82;
  localparam logic [7:0]  WP_BLK_LOW_MAX   = 8'h01;
  localparam logic [7:0]  WP_BLK_HIGH_MIN  = 8'h84;
  // pin timing in nanoseconds (arbitrary defaults, shortenable)
  localparam int unsigned RESET_PULSE_MIN_NS   = 500;
  localparam int unsigned RESET_RECOVERY_A_NS  = 50;
  localparam int unsigned RESET_RECOVERY_B_NS  = 200;
  localparam int unsigned WE_PULSE_NS          = 35;
  localparam int unsigned WE_HIGH_NS           = 30;
  localparam int unsigned CYC_RESET_PULSE =
    (RESET_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CYC_RECOVERY =
    ((RESET_RECOVERY_A_NS > RESET_RECOVERY_B_NS ? RESET_RECOVERY_A_NS
      : RESET_RECOVERY_B_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CYC_WE_LOW =
    (WE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CYC_WE_HIGH =
    (WE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 16;

  typedef enum logic [5:0] {
    ST_RST_HOLD = 6'b000001,
    ST_RECOVER  = 6'b000010,
    ST_WAIT_RDY = 6'b000100,
    ST_IDLE     = 6'b001000,
    ST_WE_LOW   = 6'b010000,
    ST_WE_HIGH  = 6'b100000
  } bbw_state_type;
endpackage

// >>> common/bbw_dec_if.sv
// Purpose: address-decode carrier between controller and decoder
// Assumes: same clock domain, combinational answer
// Notes:   none
`timescale 1ns/1ps
interface bbw_dec_if;
  logic [23:0] addr;
  logic [7:0]  blk;
  logic [1:0]  bank;
  logic        outer_blk;
  logic        param_blk;
  modport requester (output addr, input blk, bank, outer_blk, param_blk);
  modport decoder (input addr, output blk, bank, outer_blk, param_blk);
endinterface

// >>> logic/bbw_block_decode.sv
// Purpose: word address to bank and block decode
// Assumes: 24-bit word address
// Notes:   purely combinational
`timescale 1ns/1ps
module bbw_block_decode
  import bbw_pkg::*;
(
  // decode carrier
  bbw_dec_if.decoder dec
);
  logic [23:0] a;
  logic [23:0] off;
  assign a = dec.addr;

  always_comb begin
    off = 24'h000000;
    if (a < LOW_MAIN_BASE) begin
      dec.blk = 8'(a >> 15);
    end else if (a >= TOP_PARAM_BASE) begin
      off = a - TOP_PARAM_BASE;
      dec.blk = BLK_TOP_PARAM0 + 8'(off >> 15);
    end else begin
      off = a - LOW_MAIN_BASE;
      dec.blk = PARAM_BLKS_LOW + 8'(off >> 17);
    end
    // bank boundaries by comparison
    if (a < BANK_B_BASE) dec.bank = 2'h0;
    else if (a < BANK_C_BASE) dec.bank = 2'h1;
    else if (a < BANK_D_BASE) dec.bank = 2'h2;
    else dec.bank = 2'h3;
  end

  assign dec.param_blk = (a < LOW_MAIN_BASE) || (a >= TOP_PARAM_BASE);
  assign dec.outer_blk = (dec.blk <= WP_BLK_LOW_MAX) ||
                         (dec.blk >= WP_BLK_HIGH_MIN);
  // no clock here: the decode is cross-checked in the controller
endmodule // bbw_block_decode

// >>> logic/bbw_host_ctrl.sv
// Functional notes
// - each command cycle is one write-strobe pulse
// - reset held low at least minimum pulse
// - wait later recovery delay after reset release
// - no bus cycle until ready/busy released
//
// Purpose: host side driver of the flash reset, write and protect pins
// Assumes: ready/busy input pulled up externally, pins asynchronous
// Notes:   reads are not sequenced here; only command writes
`timescale 1ns/1ps
module bbw_host_ctrl
  import bbw_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // user command port
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [23:0] cmd_addr,
  input  wire logic [15:0] cmd_data,
  input  wire logic        cmd_is_modify,
  input  wire logic        reset_req,
  input  wire logic        wp_enable,
  input  wire logic        fast_prog_en,
  output logic             cmd_done,
  output logic             cmd_refused,
  output logic [1:0]       cmd_bank_r,
  output logic [7:0]       cmd_blk_r,
  output logic             flash_busy,
  // flash pins
  output logic [23:0]      fl_addr_r,
  output logic [15:0]      fl_dq_o_r,
  output logic             fl_dq_oe_r,
  output logic             fl_ce_n_r,
  output logic             fl_oe_n_r,
  output logic             fl_we_n_r,
  output logic             fl_rst_n_r,
  output logic             fl_wp_low_r,
  output logic             fl_vpp_high_r,
  input  wire logic        ready_busy_od
);
  bbw_state_type    state_r;
  bbw_state_type    state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic             rb_meta_r;
  logic             rb_sync_r;
  logic             accept;
  logic             refuse;

  bbw_dec_if dec ();
  assign dec.addr = cmd_addr;
  bbw_block_decode u_dec (.dec(dec));

  // ready/busy is asynchronous to us and may be shared
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rb_meta_r <= 1'b1;
      rb_sync_r <= 1'b1;
    end else begin
      rb_meta_r <= ready_busy_od;
      rb_sync_r <= rb_meta_r;
    end
  end
  // a released line reads high through the pull-up, so read and suspend
  // modes count as ready; an aborted operation keeps the line low
  assign flash_busy = !rb_sync_r;

  // no write goes out while the part cannot take one, e.g. after a supply
  // lockout abort; reset_req wins so a command is never taken then dropped
  assign cmd_ready = (state_r == ST_IDLE) && rb_sync_r &&
                     !reset_req;
  // modify to outer block under protection would be dropped by the part
  assign refuse = cmd_ready && cmd_valid && cmd_is_modify &&
                  fl_wp_low_r && dec.outer_blk;
  assign accept = cmd_ready && cmd_valid && !refuse;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RST_HOLD: if (cnt_r == 16'(CYC_RESET_PULSE - 1))
        state_nxt = ST_RECOVER;
      ST_RECOVER: if (cnt_r == 16'(CYC_RECOVERY - 1))
        state_nxt = ST_WAIT_RDY;
      ST_WAIT_RDY: if (rb_sync_r) state_nxt = ST_IDLE;
      ST_IDLE: begin
        if (reset_req) state_nxt = ST_RST_HOLD;
        else if (accept) state_nxt = ST_WE_LOW;
      end
      ST_WE_LOW: if (cnt_r == 16'(CYC_WE_LOW - 1))
        state_nxt = ST_WE_HIGH;
      ST_WE_HIGH: if (cnt_r == 16'(CYC_WE_HIGH - 1))
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) state_r <= ST_RST_HOLD;
    else state_r <= state_nxt;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) cnt_r <= '0;
    else if (state_nxt != state_r) cnt_r <= '0;
    else cnt_r <= cnt_r + 16'h0001;
  end

  // pins
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fl_rst_n_r <= 1'b0;
      fl_we_n_r  <= 1'b1;
      fl_ce_n_r  <= 1'b1;
      fl_oe_n_r  <= 1'b1;
      fl_dq_oe_r <= 1'b0;
      fl_addr_r  <= '0;
      fl_dq_o_r  <= '0;
      cmd_bank_r <= '0;
      cmd_blk_r  <= '0;
    end else begin
      fl_rst_n_r <= (state_nxt != ST_RST_HOLD);
      fl_we_n_r  <= (state_nxt != ST_WE_LOW);
      // chip enable high outside writes keeps the part in standby
      fl_ce_n_r  <= !(state_nxt == ST_WE_LOW ||
                      state_nxt == ST_WE_HIGH);
      fl_oe_n_r  <= 1'b1;
      fl_dq_oe_r <= (state_nxt == ST_WE_LOW ||
                     state_nxt == ST_WE_HIGH);
      if (accept) begin
        fl_addr_r  <= cmd_addr;
        fl_dq_o_r  <= cmd_data;
        cmd_bank_r <= dec.bank;
        cmd_blk_r  <= dec.blk;
      end
    end
  end

  // protect pin: high-voltage level wins over write protect
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fl_wp_low_r   <= 1'b0;
      fl_vpp_high_r <= 1'b0;
    end else if (state_r != ST_WE_LOW) begin
      fl_wp_low_r   <= wp_enable && !fast_prog_en;
      fl_vpp_high_r <= fast_prog_en;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmd_done    <= 1'b0;
      cmd_refused <= 1'b0;
    end else begin
      cmd_done    <= (state_r == ST_WE_HIGH) && (state_nxt == ST_IDLE);
      cmd_refused <= refuse;
    end
  end

  // assertion helper: cycles the reset pin has been held low, saturating
  logic [CNT_W-1:0] rst_low_cnt_r;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_low_cnt_r <= '0;
    end else if (fl_rst_n_r) begin
      rst_low_cnt_r <= '0;
    end else if (rst_low_cnt_r != '1) begin
      rst_low_cnt_r <= rst_low_cnt_r + 16'h0001;
    end
  end

  AST_RST_PULSE: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    $rose(fl_rst_n_r) |-> rst_low_cnt_r >= 16'(CYC_RESET_PULSE))
    else $error("reset pulse too short");
  AST_NO_CYCLE_BUSY: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    $fell(fl_we_n_r) |-> $past(rb_sync_r, 1))
    else $error("write started while busy");
  AST_WE_PULSE: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    $fell(fl_we_n_r) |-> !fl_we_n_r [*7] ##1 fl_we_n_r)
    else $error("write strobe width wrong");
  AST_CE_WITH_WE: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    !fl_we_n_r |-> !fl_ce_n_r && fl_dq_oe_r)
    else $error("strobe without chip enable");
  AST_PROT_DROP: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    refuse |=> cmd_refused && fl_we_n_r)
    else $error("protected command issued");
  AST_RECOVER: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    $rose(fl_rst_n_r) |-> fl_we_n_r [*8])
    else $error("write during reset recovery");
  AST_BANK_B: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    accept && cmd_addr == BANK_B_BASE |=>
      cmd_blk_r == BLK_FIRST_BANK_B && cmd_bank_r == 2'h1)
    else $error("bank B decode wrong");
  AST_VPP_WP: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    !(fl_vpp_high_r && fl_wp_low_r))
    else $error("protect pin conflict");
  // decoder cross-checks: block number against the parameter-block compare,
  // and the guarded blocks against plain address bounds
  AST_BLK_RANGE: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    cmd_valid |-> dec.blk <= BLK_LAST &&
      dec.param_blk == (dec.blk < PARAM_BLKS_LOW ||
                        dec.blk >= BLK_TOP_PARAM0))
    else $error("block number out of range");
  AST_OUTER_ADDR: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    cmd_valid |-> dec.outer_blk == (cmd_addr < 2 * PARAM_BLK_WORDS ||
      cmd_addr >= TOP_PARAM_BASE + 2 * PARAM_BLK_WORDS))
    else $error("outer block decode wrong");
  COV_WRITE: cover property (@(posedge clk_sys) disable iff (!arst_n)
    cmd_done);
  COV_REFUSE: cover property (@(posedge clk_sys) disable iff (!arst_n)
    cmd_refused);
  COV_RESET: cover property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(fl_rst_n_r));
  COV_FAST_PROG: cover property (@(posedge clk_sys) disable iff (!arst_n)
    cmd_done && fl_vpp_high_r);
  COV_OUTER_OPEN: cover property (@(posedge clk_sys) disable iff (!arst_n)
    cmd_done && !fl_wp_low_r && cmd_blk_r <= WP_BLK_LOW_MAX);
endmodule // bbw_host_ctrl

// >>> tb/bbw_flash_model.sv
// Purpose: behavioural flash device facing the host controller
// Assumes: ready/busy line pulled up outside, model only pulls it low
// Notes:   every accepted strobe is treated as a program, busy_len long
`timescale 1ns/1ps
module bbw_flash_model (
  // clock
  input  wire logic        clk_sys,
  // flash pins
  input  wire logic [23:0] fl_addr_r,
  input  wire logic        fl_dq_oe_r,
  input  wire logic        fl_ce_n_r,
  input  wire logic        fl_we_n_r,
  input  wire logic        fl_rst_n_r,
  input  wire logic        fl_wp_low_r,
  input  wire logic        fl_vpp_high_r,
  // behaviour
  input  wire logic [7:0]  busy_len,
  output logic             rb_pull_low,
  output int               strobes
);
  logic       we_d_r, rst_d_r, outer;
  logic [7:0] busy_cnt_r;
  initial strobes = 0;
  // outer blocks 0,1,132,133
  assign outer = fl_addr_r < 24'h010000 || fl_addr_r >= 24'hFF0000;
  always @(posedge clk_sys) begin
    we_d_r  <= fl_we_n_r;
    rst_d_r <= fl_rst_n_r;
    if (!fl_rst_n_r) begin
      busy_cnt_r <= 8'h00;
    end else if (!rst_d_r) begin
      busy_cnt_r <= busy_len;
    end else if (fl_we_n_r && !we_d_r && !fl_ce_n_r && fl_dq_oe_r) begin
      strobes <= strobes + 1;
      // protected outer blocks ignore the cycle
      if (!(fl_wp_low_r && outer) || fl_vpp_high_r) begin
        busy_cnt_r <= busy_len;
      end
    end else if (busy_cnt_r != 8'h00) begin
      busy_cnt_r <= busy_cnt_r - 8'h01;
    end
  end
  // open drain: only ever pulls low
  assign rb_pull_low = busy_cnt_r != 8'h00;
endmodule // bbw_flash_model

// >>> tb/bank_block_decode_write_protect_tb.sv
// Purpose: self-checking bench of the flash host controller
// Assumes: controller timing defaults from the package
// Notes:   corner addresses sit on block and bank boundaries
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin n_errors++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module bank_block_decode_write_protect_tb;
  import bbw_pkg::*;
  logic clk_sys, arst_n, cmd_valid, cmd_ready, cmd_is_modify, reset_req;
  logic wp_enable, fast_prog_en, cmd_done, cmd_refused, flash_busy;
  logic [23:0] cmd_addr, fl_addr_r;
  logic [15:0] cmd_data, fl_dq_o_r;
  logic [1:0]  cmd_bank_r;
  logic [7:0]  cmd_blk_r, busy_len;
  logic fl_dq_oe_r, fl_ce_n_r, fl_oe_n_r, fl_we_n_r, fl_rst_n_r;
  logic fl_wp_low_r, fl_vpp_high_r, rb_pull_low, ready_busy_od;
  int n_errors = 0, checks = 0, strobes, seed = 83202;
  logic [23:0] corner [17] = '{24'h000000, 24'h007FFF, 24'h008000,
    24'h00FFFF, 24'h010000, 24'h020000, 24'h1FFFFF, 24'h200000,
    24'h7FFFFF, 24'h800000, 24'hDFFFFF, 24'hE00000, 24'hFDFFFF,
    24'hFE0000, 24'hFEFFFF, 24'hFF0000, 24'hFFFFFF};
  assign ready_busy_od = rb_pull_low ? 1'b0 : 1'b1; // pull-up
  bbw_host_ctrl dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_is_modify(cmd_is_modify),
    .reset_req(reset_req), .wp_enable(wp_enable),
    .fast_prog_en(fast_prog_en), .cmd_done(cmd_done),
    .cmd_refused(cmd_refused), .cmd_bank_r(cmd_bank_r),
    .cmd_blk_r(cmd_blk_r), .flash_busy(flash_busy), .fl_addr_r(fl_addr_r),
    .fl_dq_o_r(fl_dq_o_r), .fl_dq_oe_r(fl_dq_oe_r), .fl_ce_n_r(fl_ce_n_r),
    .fl_oe_n_r(fl_oe_n_r), .fl_we_n_r(fl_we_n_r), .fl_rst_n_r(fl_rst_n_r),
    .fl_wp_low_r(fl_wp_low_r), .fl_vpp_high_r(fl_vpp_high_r),
    .ready_busy_od(ready_busy_od));
  bbw_flash_model u_flash (.clk_sys(clk_sys), .fl_addr_r(fl_addr_r),
    .fl_dq_oe_r(fl_dq_oe_r), .fl_ce_n_r(fl_ce_n_r), .fl_we_n_r(fl_we_n_r),
    .fl_rst_n_r(fl_rst_n_r), .fl_wp_low_r(fl_wp_low_r),
    .fl_vpp_high_r(fl_vpp_high_r), .busy_len(busy_len),
    .rb_pull_low(rb_pull_low), .strobes(strobes));
  function automatic logic [7:0] exp_blk(logic [23:0] a);
    if (a < 24'h020000) return 8'(a[16:15]);
    if (a >= 24'hFE0000) return 8'h82 + 8'(a[16:15]);
    return 8'h03 + 8'(a[23:17]);
  endfunction
  function automatic logic [1:0] exp_bank(logic [23:0] a);
    return a < 24'h200000 ? 2'h0 : a < 24'h800000 ? 2'h1 :
           a < 24'hE00000 ? 2'h2 : 2'h3;
  endfunction
  task automatic complete_run;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rst_check;
    int k;
    logic ok;
    k = 0;
    while (fl_rst_n_r !== 1'b1 && k < 1000) begin @(posedge clk_sys); k++; end
    ok = k >= CYC_RESET_PULSE && k < 1000;
    `CHK("rst pulse", 1'b1, ok)
    k = 0;
    while (cmd_ready !== 1'b1 && k < 1000) begin @(posedge clk_sys); k++; end
    ok = k >= CYC_RECOVERY && k > busy_len && k < 1000;
    `CHK("recovery", 1'b1, ok)
  endtask
  task automatic run(input logic [23:0] a, input logic m, w, f);
    int k, s0;
    logic outer, rf;
    logic [15:0] d;
    @(posedge clk_sys);
    wp_enable <= w;
    fast_prog_en <= f;
    cmd_addr <= a;
    cmd_is_modify <= m;
    d = 16'($random(seed));
    cmd_data <= d;
    repeat (3) @(posedge clk_sys);
    `CHK("vpp pin", f, fl_vpp_high_r)
    `CHK("wp pin", w & ~f, fl_wp_low_r)
    outer = a < 24'h010000 || a >= 24'hFF0000;
    rf = m & w & ~f & outer;
    s0 = strobes;
    cmd_valid <= 1'b1;
    k = 0;
    do begin @(posedge clk_sys); k++; end while (cmd_ready !== 1'b1 && k < 400);
    cmd_valid <= 1'b0;
    // refused pulse and strobe pins stand right after the take edge
    #1;
    `CHK("strobe low", rf, fl_we_n_r)
    if (!rf) `CHK("addr pin", a, fl_addr_r)
    if (!rf) `CHK("data pin", d, fl_dq_o_r)
    `CHK("output enable", 1'b1, fl_oe_n_r)
    k = 0;
    while (cmd_done !== 1'b1 && cmd_refused !== 1'b1 && k < 40) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    `CHK("refused", rf, cmd_refused)
    `CHK("latency", rf ? 0 : CYC_WE_LOW + CYC_WE_HIGH, k)
    `CHK("strobes", rf ? 0 : 1, strobes - s0)
    if (!rf) `CHK("block", exp_blk(a), cmd_blk_r)
    if (!rf) `CHK("bank", exp_bank(a), cmd_bank_r)
    `CHK("standby", 1'b1, fl_ce_n_r)
    `CHK("bus released", 1'b0, fl_dq_oe_r)
    if (!rf && busy_len > 8'h10 && !(w & ~f & outer)) begin
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK("busy", 1'b1, flash_busy)
      `CHK("held", 1'b0, cmd_ready)
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_errors++;
    complete_run();
  end
  initial begin
    {arst_n, cmd_valid, cmd_is_modify, reset_req} = '0;
    {wp_enable, fast_prog_en, cmd_addr, cmd_data} = '0;
    busy_len = 8'h1E;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rst_check();
    // protected outer blocks, then the same after write-protect returns high
    foreach (corner[i]) run(corner[i], 1'b1, 1'b1, 1'b0);
    foreach (corner[i]) run(corner[i], 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 40; i++) begin
      busy_len <= $random(seed) & 1 ? 8'h1E : 8'h02;
      run(24'($random(seed)), 1'($random(seed)), 1'($random(seed)),
          1'($random(seed)));
    end
    @(posedge clk_sys);
    reset_req <= 1'b1;
    while (fl_rst_n_r !== 1'b0) @(posedge clk_sys);
    reset_req <= 1'b0;
    rst_check();
    run(24'hFF8000, 1'b1, 1'b1, 1'b1);
    complete_run();
  end
endmodule // bank_block_decode_write_protect_tb
